// ### nocr_regs.sv
`timescale 1ns/10ps
module nocr_regs import nocr_pkg::*; #(
  parameter int RETRY_UNIT_CYCLES = RETRY_UNIT_CYC,
  parameter int LCP_UNIT_CYCLES   = LCP_UNIT_CYC
) (
  input  wire logic        clock,                  // System clock
  input  wire logic        rst_n,                  // Sync reset, low
  input  wire logic [15:0] host_addr,              // Direct access address
  input  wire logic [7:0]  host_wdata,             // Write byte
  input  wire logic        host_wr,                // Write strobe
  input  wire logic        host_rd,                // Read strobe
  output logic      [7:0]  host_rdata,             // Read byte, next cycle
  input  wire logic        ind_addr_load,          // Load access address
  input  wire logic [15:0] ind_addr_value,         // Address to load
  output logic      [15:0] access_addr,            // Indirect access address
  input  wire logic        arp_clash_evt,          // Clash request seen
  input  wire logic        dest_fail_evt,          // Unreachable reply seen
  input  wire logic [31:0] dest_fail_ip,           // Failed address
  input  wire logic [15:0] dest_fail_port,         // Failed port
  input  wire logic        session_close_evt,      // PPPoE session closed
  input  wire logic [3:0]  socket_raise,           // Socket event raised
  input  wire logic [3:0]  socket_ir_zero,         // Socket register zero
  input  wire logic        auth_kind_valid,        // Auth kind agreed
  input  wire logic [15:0] auth_kind_value,        // Agreed auth kind
  input  wire logic        retry_start,            // Command awaits answer
  input  wire logic        retry_ack,              // Peer answered
  output logic             retry_due,              // Retransmit now
  output logic             retry_timeout,          // Retries exhausted
  output logic             sw_reset_pulse,         // Soft reset in progress
  output logic             echo_reply_block,       // Drop echo replies
  output logic             pppoe_enable,           // PPPoE operation
  output logic             addr_step_enable,       // Address stepping
  output logic             indirect_access_select, // Indirect mode
  output logic      [31:0] gateway_ip,             // Default gateway
  output logic      [31:0] netmask,                // Subnet mask
  output logic      [47:0] own_hw_address,         // Own hardware address
  output logic      [31:0] own_ip_address,         // Own IP address
  output logic      [15:0] retry_period,           // Units of 100 us
  output logic      [7:0]  retry_limit,            // Retransmission count
  output logic      [3:0]  rx_sock_usable,         // RX memory fitted
  output logic      [3:0]  tx_sock_usable,         // TX memory fitted
  output logic      [7:0]  lcp_magic_value,        // LCP magic number
  output logic             lcp_echo_due,           // Send LCP echo now
  output logic             int_n                   // Interrupt, low
);

  localparam int RU_W = $clog2(RETRY_UNIT_CYCLES + 1);
  localparam int LU_W = $clog2(LCP_UNIT_CYCLES + 1);

  logic              soft_rst;
  logic [7:0]        global_mode;
  logic [7:0]        interrupt_cause;
  logic [7:0]        interrupt_enable_mask;
  logic [7:0]        rx_buffer_split;
  logic [7:0]        tx_buffer_split;
  logic [7:0]        lcp_echo_period;
  logic [15:0]       ppp_auth_kind;
  logic [31:0]       failed_dest_ip;
  logic [15:0]       failed_dest_port;
  logic [7:0]        net_bytes [NET_BYTES];
  logic [7:0]        rd_value;
  logic [7:0]        next_cause;
  logic [7:0]        cause_evt;
  logic [5:0]        rx_cum [SOCKETS+1];
  logic [5:0]        tx_cum [SOCKETS+1];
  logic [3:0]        rx_fit;
  logic [3:0]        tx_fit;
  nocr_retry_state_t rt_state;
  logic [RU_W-1:0]   unit_cnt;
  logic [15:0]       units;
  logic [7:0]        attempts;
  logic [LU_W-1:0]   lcp_cnt;
  logic [7:0]        lcp_units;

  // Soft reset joins the pin reset for every register but its own flag
  wire clr = !rst_n || soft_rst;

  // Effective address: indirect mode uses the stepping access address
  wire [15:0] eff_addr = global_mode[MODE_INDIRECT] ? access_addr
                                                    : host_addr;
  wire [15:0] net_off  = eff_addr - OFS_GATEWAY;
  wire [4:0]  net_idx  = net_off[4:0];
  wire [15:0] fail_off = eff_addr - OFS_FAIL_IP;
  wire [1:0]  fail_sh  = 2'h3 - fail_off[1:0];

  // Address decode
  wire hit_mode  = eff_addr == OFS_MODE;
  wire hit_net   = eff_addr >= OFS_GATEWAY && eff_addr < OFS_NET_END;
  wire hit_cause = eff_addr == OFS_CAUSE;
  wire hit_mask  = eff_addr == OFS_MASK;
  wire hit_rp_hi = eff_addr == OFS_RETRY_PERIOD;
  wire hit_rp_lo = eff_addr == OFS_RETRY_PERIOD + 16'h0001;
  wire hit_rl    = eff_addr == OFS_RETRY_LIMIT;
  wire hit_rx    = eff_addr == OFS_RX_SPLIT;
  wire hit_tx    = eff_addr == OFS_TX_SPLIT;
  wire hit_au_hi = eff_addr == OFS_AUTH_KIND;
  wire hit_au_lo = eff_addr == OFS_AUTH_KIND + 16'h0001;
  wire hit_lp    = eff_addr == OFS_LCP_PERIOD;
  wire hit_lm    = eff_addr == OFS_LCP_MAGIC;
  wire hit_fip   = eff_addr >= OFS_FAIL_IP && eff_addr < OFS_FAIL_PORT;
  wire hit_fp_hi = eff_addr == OFS_FAIL_PORT;
  wire hit_fp_lo = eff_addr == OFS_FAIL_PORT + 16'h0001;
  wire wr_cause  = host_wr && hit_cause;
  wire host_acc  = host_wr || host_rd;

  // Read selection, big-endian, reserved bits zero
  always_comb begin
    if (hit_mode) begin
      rd_value = {soft_rst, 7'h00} | (global_mode & MODE_WR_MASK);
    end else if (hit_net) begin
      rd_value = net_bytes[net_idx];
    end else if (hit_cause) begin
      rd_value = interrupt_cause;
    end else if (hit_mask) begin
      rd_value = interrupt_enable_mask;
    end else if (hit_rp_hi) begin
      rd_value = retry_period[15:8];
    end else if (hit_rp_lo) begin
      rd_value = retry_period[7:0];
    end else if (hit_rl) begin
      rd_value = retry_limit;
    end else if (hit_rx) begin
      rd_value = rx_buffer_split;
    end else if (hit_tx) begin
      rd_value = tx_buffer_split;
    end else if (hit_au_hi) begin
      rd_value = ppp_auth_kind[15:8];
    end else if (hit_au_lo) begin
      rd_value = ppp_auth_kind[7:0];
    end else if (hit_lp) begin
      rd_value = lcp_echo_period;
    end else if (hit_lm) begin
      rd_value = lcp_magic_value;
    end else if (hit_fip) begin
      rd_value = failed_dest_ip[{fail_sh, 3'h0} +: 8];
    end else if (hit_fp_hi) begin
      rd_value = failed_dest_port[15:8];
    end else if (hit_fp_lo) begin
      rd_value = failed_dest_port[7:0];
    end else begin
      rd_value = RST_ZERO8;
    end
  end

  // Soft reset flag: set by write, clears itself after one reset cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= host_wr && hit_mode && host_wdata[MODE_SW_RESET]
                  && !soft_rst;
    end
  end

  // Read data register
  always_ff @(posedge clock) begin
    if (clr) begin
      host_rdata <= RST_ZERO8;
    end else if (host_rd) begin
      host_rdata <= rd_value;
    end
  end

  // Access address, steps after each access when enabled
  always_ff @(posedge clock) begin
    if (clr) begin
      access_addr <= 16'h0000;
    end else if (ind_addr_load) begin
      access_addr <= ind_addr_value;
    end else if (host_acc && global_mode[MODE_INDIRECT]
                 && global_mode[MODE_ADDR_STEP]) begin
      access_addr <= access_addr + 16'h0001;
    end
  end

  // Mode register, reserved bits kept zero
  always_ff @(posedge clock) begin
    if (clr) begin
      global_mode <= RST_ZERO8;
    end else if (host_wr && hit_mode) begin
      global_mode <= host_wdata & MODE_WR_MASK;
    end
  end

  assign echo_reply_block       = global_mode[MODE_ECHO_BLOCK];
  assign pppoe_enable           = global_mode[MODE_PPPOE];
  assign addr_step_enable       = global_mode[MODE_ADDR_STEP];
  assign indirect_access_select = global_mode[MODE_INDIRECT];
  assign sw_reset_pulse         = soft_rst;

  // Network address bytes, most significant byte lowest
  always_ff @(posedge clock) begin
    if (clr) begin
      for (int k = 0; k < NET_BYTES; k++) begin
        net_bytes[k] <= RST_ZERO8;
      end
    end else if (host_wr && hit_net) begin
      net_bytes[net_idx] <= host_wdata;
    end
  end

  assign gateway_ip     = {net_bytes[0], net_bytes[1], net_bytes[2],
                           net_bytes[3]};
  assign netmask        = {net_bytes[4], net_bytes[5], net_bytes[6],
                           net_bytes[7]};
  assign own_hw_address = {net_bytes[8], net_bytes[9], net_bytes[10],
                           net_bytes[11], net_bytes[12], net_bytes[13]};
  assign own_ip_address = {net_bytes[14], net_bytes[15], net_bytes[16],
                           net_bytes[17]};

  // Timing, sizing and PPP configuration registers
  always_ff @(posedge clock) begin
    if (clr) begin
      retry_period    <= RST_RETRY_PERIOD;
      retry_limit     <= RST_RETRY_LIMIT;
      rx_buffer_split <= RST_SPLIT;
      tx_buffer_split <= RST_SPLIT;
      lcp_echo_period <= RST_LCP_PERIOD;
      lcp_magic_value <= RST_ZERO8;
    end else if (host_wr) begin
      if (hit_rp_hi) retry_period[15:8] <= host_wdata;
      if (hit_rp_lo) retry_period[7:0] <= host_wdata;
      if (hit_rl) retry_limit <= host_wdata;
      if (hit_rx) rx_buffer_split <= host_wdata;
      if (hit_tx) tx_buffer_split <= host_wdata;
      if (hit_lp) lcp_echo_period <= host_wdata;
      if (hit_lm) lcp_magic_value <= host_wdata;
    end
  end

  // Mask register, reserved bit ignores writes
  always_ff @(posedge clock) begin
    if (clr) begin
      interrupt_enable_mask <= RST_ZERO8;
    end else if (host_wr && hit_mask) begin
      interrupt_enable_mask <= host_wdata & MASK_WR_MASK;
    end
  end

  // Captured status from the protocol engine
  always_ff @(posedge clock) begin
    if (clr) begin
      ppp_auth_kind    <= 16'h0000;
      failed_dest_ip   <= 32'h0000_0000;
      failed_dest_port <= 16'h0000;
    end else begin
      if (auth_kind_valid) ppp_auth_kind <= auth_kind_value;
      if (dest_fail_evt) begin
        failed_dest_ip   <= dest_fail_ip;
        failed_dest_port <= dest_fail_port;
      end
    end
  end

  // Cause events; session close counts only in PPPoE operation
  assign cause_evt = {arp_clash_evt, dest_fail_evt,
                      session_close_evt && pppoe_enable, 5'h00};

  // Cause bits: sockets follow their registers, bits 5 to 7 clear by write-one, bit 4 stays zero
  for (genvar i = 0; i < 8; i++) begin : g_cause
    if (i < SOCKETS) begin : g_sock
      assign next_cause[i] = socket_raise[i]
                             || (interrupt_cause[i] && !socket_ir_zero[i]);
    end else if (CAUSE_W1C_MASK[i]) begin : g_w1c
      assign next_cause[i] = cause_evt[i] || (interrupt_cause[i]
                             && !(wr_cause && host_wdata[i]));
    end else begin : g_rsvd
      assign next_cause[i] = 1'b0;
    end
  end

  // Cause register and interrupt pin
  always_ff @(posedge clock) begin
    if (clr) begin
      interrupt_cause <= RST_ZERO8;
      int_n           <= 1'b1;
    end else begin
      interrupt_cause <= next_cause;
      int_n           <= !(|(interrupt_cause & interrupt_enable_mask));
    end
  end

  // Buffer allocation from socket 0 upward within the per-direction memory
  assign rx_cum[0] = 6'h00;
  assign tx_cum[0] = 6'h00;
  for (genvar s = 0; s < SOCKETS; s++) begin : g_alloc
    assign rx_cum[s+1] = rx_cum[s] + (6'h01 << rx_buffer_split[2*s +: 2]);
    assign tx_cum[s+1] = tx_cum[s] + (6'h01 << tx_buffer_split[2*s +: 2]);
    assign rx_fit[s]   = rx_cum[s+1] <= BUF_TOTAL_KB;
    assign tx_fit[s]   = tx_cum[s+1] <= BUF_TOTAL_KB;
  end

  always_ff @(posedge clock) begin
    if (clr) begin
      rx_sock_usable <= 4'hf;
      tx_sock_usable <= 4'hf;
    end else begin
      rx_sock_usable <= rx_fit;
      tx_sock_usable <= tx_fit;
    end
  end

  // Retransmission timer
  wire unit_tick   = unit_cnt == RU_W'(RETRY_UNIT_CYCLES - 1);
  wire period_done = unit_tick
                     && ({1'b0, units} + 17'h00001 >= {1'b0, retry_period});
  wire give_up     = period_done && attempts >= retry_limit;

  always_ff @(posedge clock) begin
    if (clr) begin
      rt_state      <= RT_IDLE;
      unit_cnt      <= '0;
      units         <= 16'h0000;
      attempts      <= RST_ZERO8;
      retry_due     <= 1'b0;
      retry_timeout <= 1'b0;
    end else begin
      retry_due     <= 1'b0;
      retry_timeout <= 1'b0;
      case (rt_state)
        RT_IDLE: begin
          if (retry_start) begin
            rt_state <= RT_WAIT;
            unit_cnt <= '0;
            units    <= 16'h0000;
            attempts <= RST_ZERO8;
          end
        end
        RT_WAIT: begin
          if (retry_ack) begin
            rt_state <= RT_IDLE;
          end else if (retry_start) begin
            unit_cnt <= '0;
            units    <= 16'h0000;
            attempts <= RST_ZERO8;
          end else begin
            unit_cnt <= unit_tick ? '0 : unit_cnt + 1'b1;
            if (unit_tick) units <= units + 16'h0001;
            if (period_done) begin
              units <= 16'h0000;
              if (give_up) begin
                retry_timeout <= 1'b1;
                rt_state      <= RT_IDLE;
              end else begin
                retry_due <= 1'b1;
                attempts  <= attempts + 8'h01;
              end
            end
          end
        end
        default: rt_state <= RT_IDLE;
      endcase
    end
  end

  // LCP echo interval timer, runs only in PPPoE operation
  wire lcp_tick = lcp_cnt == LU_W'(LCP_UNIT_CYCLES - 1);
  wire lcp_run  = pppoe_enable && lcp_echo_period != RST_ZERO8;

  always_ff @(posedge clock) begin
    if (clr || !lcp_run) begin
      lcp_cnt      <= '0;
      lcp_units    <= RST_ZERO8;
      lcp_echo_due <= 1'b0;
    end else begin
      lcp_cnt      <= lcp_tick ? '0 : lcp_cnt + 1'b1;
      lcp_echo_due <= lcp_tick && lcp_units + 8'h01 == lcp_echo_period;
      if (lcp_tick) begin
        lcp_units <= (lcp_units + 8'h01 == lcp_echo_period) ? RST_ZERO8
                                                            : lcp_units + 8'h01;
      end
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  soft_reset_a: assert property (host_wr && hit_mode && !soft_rst
      && host_wdata[MODE_SW_RESET] |=> soft_rst ##1
      (!soft_rst && retry_period == RST_RETRY_PERIOD))
    else $error("soft reset did not complete");
  mode_fields_a: assert property (host_wr && hit_mode && !soft_rst |=>
      echo_reply_block == $past(host_wdata[MODE_ECHO_BLOCK])
      && pppoe_enable == $past(host_wdata[MODE_PPPOE]))
    else $error("mode fields not taken");
  addr_step_a: assert property (host_acc && !ind_addr_load && !soft_rst
      && indirect_access_select && addr_step_enable
      |=> access_addr == $past(access_addr) + 16'h0001)
    else $error("access address did not step");
  irq_level_a: assert property (|(interrupt_cause & interrupt_enable_mask)
      && !soft_rst |=> !int_n)
    else $error("interrupt pin not low");
  clash_set_a: assert property (arp_clash_evt && !soft_rst
      |=> interrupt_cause[7] ##1 !int_n || !interrupt_enable_mask[7])
    else $error("clash flag lost");
  dest_capture_a: assert property (dest_fail_evt && !soft_rst |=>
      failed_dest_ip == $past(dest_fail_ip) && interrupt_cause[6])
    else $error("unreachable capture wrong");
  close_gate_a: assert property (session_close_evt && !pppoe_enable
      && !interrupt_cause[5] && !soft_rst |=> !interrupt_cause[5])
    else $error("close flag set outside PPPoE");
  sock_clear_a: assert property (interrupt_cause[0] && socket_ir_zero[0]
      && !socket_raise[0] && !soft_rst |=> !interrupt_cause[0])
    else $error("socket cause did not clear");
  retry_cap_a: assert property (retry_timeout
      |-> $past(attempts) >= $past(retry_limit))
    else $error("timeout before retry limit");
  split_fit_a: assert property (rx_buffer_split == RST_SPLIT && !soft_rst
      ##1 rx_buffer_split == RST_SPLIT |-> rx_sock_usable == 4'hf)
    else $error("default split not usable");

  soft_reset_c:  cover property (soft_rst ##1 !soft_rst);
  irq_raise_c:   cover property (int_n ##1 !int_n);
  retry_giveup_c: cover property (retry_due ##[1:1000] retry_timeout);
  lcp_echo_c:    cover property (lcp_echo_due);

endmodule : nocr_regs

// ### nocr_pkg.sv
package nocr_pkg;
  // Register offsets
  localparam logic [15:0] OFS_MODE         = 16'h0000;
  localparam logic [15:0] OFS_GATEWAY      = 16'h0001;
  localparam logic [15:0] OFS_NET_END      = 16'h0013;
  localparam logic [15:0] OFS_CAUSE        = 16'h0015;
  localparam logic [15:0] OFS_MASK         = 16'h0016;
  localparam logic [15:0] OFS_RETRY_PERIOD = 16'h0017;
  localparam logic [15:0] OFS_RETRY_LIMIT  = 16'h0019;
  localparam logic [15:0] OFS_RX_SPLIT     = 16'h001a;
  localparam logic [15:0] OFS_TX_SPLIT     = 16'h001b;
  localparam logic [15:0] OFS_AUTH_KIND    = 16'h001c;
  localparam logic [15:0] OFS_LCP_PERIOD   = 16'h0028;
  localparam logic [15:0] OFS_LCP_MAGIC    = 16'h0029;
  localparam logic [15:0] OFS_FAIL_IP      = 16'h002a;
  localparam logic [15:0] OFS_FAIL_PORT    = 16'h002e;
  localparam int          NET_BYTES        = 18;
  // Mode bit positions and writable bits
  localparam int          MODE_SW_RESET    = 7;
  localparam int          MODE_ECHO_BLOCK  = 4;
  localparam int          MODE_PPPOE       = 3;
  localparam int          MODE_ADDR_STEP   = 1;
  localparam int          MODE_INDIRECT    = 0;
  localparam logic [7:0]  MODE_WR_MASK     = 8'h1b;
  // Cause and mask layout
  localparam logic [7:0]  CAUSE_W1C_MASK   = 8'he0;
  localparam logic [7:0]  MASK_WR_MASK     = 8'hef;
  localparam int          SOCKETS          = 4;
  // Reset values
  localparam logic [7:0]  RST_ZERO8        = 8'h00;
  localparam logic [15:0] RST_RETRY_PERIOD = 16'h07d0;
  localparam logic [7:0]  RST_RETRY_LIMIT  = 8'h08;
  localparam logic [7:0]  RST_SPLIT        = 8'h55;
  localparam logic [7:0]  RST_LCP_PERIOD   = 8'h28;
  // Buffer memory per direction in KB
  localparam logic [5:0]  BUF_TOTAL_KB     = 6'h08;
  // Timing
  localparam int          CLK_PERIOD_NS    = 8;
  localparam int          RETRY_UNIT_NS    = 100_000;
  localparam int          LCP_UNIT_NS      = 25_000_000;
  localparam int          RETRY_UNIT_CYC   = RETRY_UNIT_NS / CLK_PERIOD_NS;
  localparam int          LCP_UNIT_CYC     = LCP_UNIT_NS / CLK_PERIOD_NS;
  // Retransmission timer states
  typedef enum logic {RT_IDLE, RT_WAIT} nocr_retry_state_t;
endpackage : nocr_pkg

// ### nocr_host.sv
`timescale 1ns/10ps
// Host end of the byte register bus
module nocr_host (
  input  wire logic [7:0]  host_rdata, // Read byte
  input  wire logic        clock,      // System clock
  output logic      [15:0] host_addr,  // Byte address
  output logic      [7:0]  host_wdata, // Write byte
  output logic             host_wr,    // Write strobe
  output logic             host_rd     // Read strobe
);
  // Idle bus from time zero
  initial begin
    host_addr = 16'h0000;
    host_wdata = 8'h00;
    host_wr = 1'b0;
    host_rd = 1'b0;
  end
  // One write; data scrambled once released
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    host_addr <= a;
    host_wdata <= d;
    host_wr <= 1'b1;
    @(posedge clock);
    host_wr <= 1'b0;
    host_wdata <= ~d;
  endtask : wr
  // One read; byte taken after the answer settles
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clock);
    host_addr <= a;
    host_rd <= 1'b1;
    @(posedge clock);
    host_rd <= 1'b0;
    #1;
    d = host_rdata;
  endtask : rd
endmodule : nocr_host

// ### tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [9:0]  ev = '0;
  logic [3:0]  sz = 4'hf;
  logic [15:0] iav = '0, fport = '0, auth = '0, ha, aa;
  logic [31:0] fip = '0, gw;
  logic [7:0]  rb, hw, hr;
  logic [3:0]  rxu;
  logic        wr, rd, due, tmo, eb, int_n;
  int          errors = 0, checks_done = 0, nd, nt;
  logic [15:0] ra [9] = '{16'h17, 16'h18, 16'h19, 16'h1a, 16'h1b,
                          16'h28, 16'h29, 16'h1c, 16'h00};
  logic [7:0]  rv [9] = '{8'h07, 8'hd0, 8'h08, 8'h55, 8'h55,
                          8'h28, 8'h00, 8'h00, 8'h00};
  // Clock and parts
  always #4 clock = ~clock;
  nocr_host host (.clock, .host_rdata(hr), .host_addr(ha),
    .host_wdata(hw), .host_wr(wr), .host_rd(rd));
  nocr_regs #(.RETRY_UNIT_CYCLES(4), .LCP_UNIT_CYCLES(4)) uut (
    .clock, .rst_n, .host_addr(ha), .host_wdata(hw), .host_wr(wr),
    .host_rd(rd), .host_rdata(hr), .ind_addr_load(ev[9]),
    .ind_addr_value(iav), .access_addr(aa), .arp_clash_evt(ev[0]),
    .dest_fail_evt(ev[1]), .dest_fail_ip(fip), .dest_fail_port(fport),
    .session_close_evt(ev[2]), .socket_raise(ev[8:5]),
    .socket_ir_zero(sz), .auth_kind_valid(ev[3]), .auth_kind_value(auth),
    .retry_start(ev[4]), .retry_ack(1'b0), .retry_due(due),
    .retry_timeout(tmo), .sw_reset_pulse(), .echo_reply_block(eb),
    .pppoe_enable(), .addr_step_enable(), .indirect_access_select(),
    .gateway_ip(gw), .netmask(), .own_hw_address(), .own_ip_address(),
    .retry_period(), .retry_limit(), .rx_sock_usable(rxu),
    .tx_sock_usable(), .lcp_magic_value(), .lcp_echo_due(), .int_n);
  // Compare, count, report
  task automatic cmp(string nm, logic [47:0] e, logic [47:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : cmp
  // Read one register byte and compare
  task automatic rc(input logic [15:0] a, input logic [7:0] e);
    host.rd(a, rb);
    cmp($sformatf("reg %h", a), {40'h0, e}, {40'h0, rb});
  endtask : rc
  // One-cycle event pulse, then settle
  task automatic pulse(input logic [9:0] p);
    @(posedge clock);
    ev <= p;
    @(posedge clock);
    ev <= '0;
    repeat (2) @(posedge clock);
  endtask : pulse
  // Verdict
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim
  // Hang guard
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    end_sim();
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    foreach (ra[i]) rc(ra[i], rv[i]);
    cmp("rx_usable", 48'hf, {44'h0, rxu});
    host.wr(16'h1a, 8'haa);
    @(posedge clock);
    #1;
    cmp("rx_usable", 48'h3, {44'h0, rxu});
    $display("test reset done");
    host.wr(16'h00, 8'h70);
    rc(16'h00, 8'h10);
    cmp("echo_block", 48'h1, {47'h0, eb});
    for (int i = 0; i < 4; i++)
      host.wr(16'(1 + i), 8'(32'hc0a80001 >> (24 - 8 * i)));
    #1;
    cmp("gateway", 48'hc0a80001, {16'h0, gw});
    host.wr(16'h16, 8'hff);
    rc(16'h16, 8'hef);
    host.wr(16'h13, 8'h5a);
    rc(16'h13, 8'h00);
    host.wr(16'h1c, 8'hff);
    rc(16'h1c, 8'h00);
    $display("test storage done");
    pulse(10'h001);
    cmp("int_n", 48'h0, {47'h0, int_n});
    host.wr(16'h15, 8'h80);
    rc(16'h15, 8'h00);
    cmp("int_n", 48'h1, {47'h0, int_n});
    fip <= 32'hc0a8000b;
    fport <= 16'h1388;
    pulse(10'h002);
    for (int i = 0; i < 6; i++)
      rc(16'(16'h2a + i), 8'(48'hc0a8000b1388 >> (40 - 8 * i)));
    host.wr(16'h15, 8'h40);
    pulse(10'h004);
    rc(16'h15, 8'h00);
    host.wr(16'h00, 8'h08);
    pulse(10'h004);
    rc(16'h15, 8'h20);
    host.wr(16'h15, 8'h20);
    sz <= 4'h0;
    pulse(10'h080);
    host.wr(16'h15, 8'h04);
    rc(16'h15, 8'h04);
    sz <= 4'hf;
    rc(16'h15, 8'h00);
    auth <= 16'hc223;
    pulse(10'h008);
    rc(16'h1c, 8'hc2);
    $display("test events done");
    host.wr(16'h00, 8'h0b);
    iav <= 16'h0005;
    pulse(10'h200);
    repeat (4) host.wr(16'h00, 8'hff);
    #1;
    cmp("access_addr", 48'h9, {32'h0, aa});
    iav <= 16'h0000;
    pulse(10'h200);
    host.wr(16'h33, 8'h00);
    rc(16'h08, 8'hff);
    $display("test indirect done");
    host.wr(16'h00, 8'h80);
    rc(16'h01, 8'h00);
    rc(16'h00, 8'h00);
    host.wr(16'h17, 8'h00);
    host.wr(16'h18, 8'h01);
    host.wr(16'h19, 8'h01);
    @(posedge clock);
    ev <= 10'h010;
    nd = 0;
    nt = 0;
    repeat (30) begin
      @(posedge clock);
      ev <= '0;
      #1;
      nd += int'(due);
      nt += int'(tmo);
    end
    cmp("retries", 48'h1, 48'(nd));
    cmp("timeouts", 48'h1, 48'(nt));
    $display("test reset and retry done");
    end_sim();
  end
endmodule : tb_top
